// File: src/gtp_timer.sv
// Capture timer with prescaler, postscaler and time-of-day count
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps

// How it works
// [RULE1] Time-of-day fields packed, gaps read zero; code masks load and count reads only, the capture read is unmasked
// [RULE2] Software picks 32.768 kHz, divide 256
// [RULE3] Format field picks binary or time-of-day
// [RULE4] Direction bit: set up, clear down
// [RULE5] Run bit enables counting, cleared at reset
// [RULE6] Mode bit: set periodic, clear free-running
// [RULE7] Periodic restarts from load, free from extreme
// [RULE8] Periodic overflow reloads count from load register
// [RULE9] Prescaler divides by 1, 16, 256, 32768
// [RULE10] Clock select picks one of four sources
// [RULE11] First event assertion copies count, keeps running
// [RULE12] Only enabled interrupt sources reach capture
// [RULE13] Capture enable bit and five-bit event select
// [RULE14] Fixed event numbers, others reserved
// [RULE15] Postscale write sets target, zero means one
// [RULE16] Postscaler counts one to 256 timeouts; code takes an 8-bit target, so at most 255
// [RULE17] Bit 23 enables the postscaler
// [RULE18] Read-only flag set on postscale match
// [RULE19] Bit 18 picks postscale or timeout interrupt
// [RULE20] Any clear-register write drops pending interrupt
// [RULE21] Low-power keeps oscillator and pin counting
// [RULE22] Software writes zero to bits 22:20
// [RULE23] Interrupt at zero down or full scale up
// [RULE24] Time-of-day fields roll over and carry
module gtp_timer
  import gtp_pkg::*;
#(
  parameter int EVENT_N = NUM_EVENTS
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address and data
  input  wire logic [31:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Count sources, one-cycle enables or pin level
  input  wire logic               osc_tick,
  input  wire logic               core_div_tick,
  input  wire logic               core_tick,
  input  wire logic               external_count_pin,
  input  wire logic               low_power_mode,
  // Enabled interrupt sources, levels
  input  wire logic [EVENT_N-1:0] event_irq,
  // Pending timer interrupt
  output logic                    timer_irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (EVENT_N != NUM_EVENTS)
  begin : g_bad_events
    $error("EVENT_N must equal the number of event inputs");
  end

  localparam gtp_state_t RST_STATE = '{
    load: RST_LOAD, value: RST_VALUE, snap: RST_SNAP,
    ps_target: RST_CONFIG[CFG_PS_LSB +: 8], ps_cnt: RST_CONFIG[CFG_PS_LSB +: 8],
    clk_sel: CLK_OSC, fmt: FMT_BIN, arready: 1'b1, awready: 1'b1, wready: 1'b1,
    default: '0};

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Word address match
  function automatic logic reg_hit(input logic [31:0] a, input logic [31:0] off);
    reg_hit = (a[31:2] == off[31:2]);
  endfunction : reg_hit

  // Prescaler mask, undefined codes divide by one
  function automatic logic [14:0] div_mask(input logic [3:0] code);
    case (code)
      4'h4:    div_mask = 15'h000f;
      4'h8:    div_mask = 15'h00ff;
      4'hf:    div_mask = 15'h7fff;
      default: div_mask = 15'h0000;
    endcase
  endfunction : div_mask

  // Hour limit of the selected format
  function automatic logic [7:0] hour_max(input gtp_fmt_t f);
    hour_max = (f == FMT_TOD255) ? TOD_H255_MAX : TOD_H24_MAX;
  endfunction : hour_max

  // Full-scale count in each format
  function automatic logic [31:0] full_scale(input gtp_fmt_t f);
    if (f[1])
      full_scale = {hour_max(f), 2'b00, TOD_MS_MAX, 2'b00, TOD_MS_MAX, 1'b0, TOD_TICK_MAX};
    else
      full_scale = 32'hffffffff;
  endfunction : full_scale

  // One time-of-day step with carries, terminal values handled outside
  function automatic logic [31:0] tod_step(input logic [31:0] v, input logic up,
                                           input logic [7:0] hmax);
    logic [6:0] t;
    logic [5:0] s;
    logic [5:0] m;
    logic [7:0] h;
    t = v[6:0];
    s = v[13:8];
    m = v[21:16];
    h = v[31:24];
    if (up)
    begin
      if (t != TOD_TICK_MAX) t = t + 7'h01;
      else
      begin
        t = 7'h00;
        if (s != TOD_MS_MAX) s = s + 6'h01;
        else
        begin
          s = 6'h00;
          if (m != TOD_MS_MAX) m = m + 6'h01;
          else
          begin
            m = 6'h00;
            h = (h != hmax) ? h + 8'h01 : 8'h00;
          end
        end
      end
    end
    else
    begin
      if (t != 7'h00) t = t - 7'h01;
      else
      begin
        t = TOD_TICK_MAX;
        if (s != 6'h00) s = s - 6'h01;
        else
        begin
          s = TOD_MS_MAX;
          if (m != 6'h00) m = m - 6'h01;
          else
          begin
            m = TOD_MS_MAX;
            h = (h != 8'h00) ? h - 8'h01 : hmax;
          end
        end
      end
    end
    tod_step = {h, 2'b00, m, 2'b00, s, 1'b0, t};
  endfunction : tod_step

  // Event numbers that name a real source
  function automatic logic event_valid(input logic [4:0] sel);
    event_valid = (sel >= 5'h01 && sel <= 5'h04) || (sel >= 5'h08 && sel <= 5'h11);
  endfunction : event_valid

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction : merge

  // ----------------------------------------------------------------
  // State and helper signals
  // ----------------------------------------------------------------
  gtp_state_t  st;
  gtp_state_t  nx;
  logic        src_tick;
  logic        cnt_tick;
  logic        timeout;
  logic        ps_hit;
  logic        capture;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] restart_val;
  logic [31:0] cfg_view;
  logic [31:0] cfg_new;
  logic [31:0] fmt_mask;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nx = st;
    fmt_mask = st.fmt[1] ? TOD_MASK : 32'hffffffff;                // [RULE1] [RULE3]
    cfg_view = {st.ps_cnt, st.ps_en, 3'b000, st.match, st.origin, st.snap_en,
                st.snap_sel, 1'b0, st.clk_sel, st.dir, st.run, st.mode, st.fmt, st.pre};
    // Source select with low-power gating of core-derived clocks
    case (st.clk_sel)                                               // [RULE10]
      CLK_OSC:      src_tick = osc_tick;
      CLK_CORE_DIV: src_tick = core_div_tick && !low_power_mode;    // [RULE21]
      CLK_CORE:     src_tick = core_tick && !low_power_mode;
      CLK_PIN:      src_tick = external_count_pin && !st.pin_prev;
      default:      src_tick = 1'b0;
    endcase
    nx.pin_prev = external_count_pin;
    // Prescaler, cleared while stopped
    cnt_tick = st.run && src_tick &&                                // [RULE5]
               ((st.pre_cnt & div_mask(st.pre)) == div_mask(st.pre)); // [RULE9]
    if (!st.run)
      nx.pre_cnt = 15'h0000;
    else if (src_tick)
      nx.pre_cnt = st.pre_cnt + 15'h0001;
    // Restart point in each mode
    if (st.mode)                                                    // [RULE6]
      restart_val = st.load & fmt_mask;                             // [RULE7] [RULE8]
    else
      restart_val = st.dir ? 32'h00000000 : full_scale(st.fmt);     // [RULE7]
    // Counter step, timeout at zero or full scale
    timeout = cnt_tick &&
              (st.value == (st.dir ? full_scale(st.fmt) : 32'h00000000)); // [RULE23] [RULE4]
    if (timeout)
      nx.value = restart_val;
    else if (cnt_tick && st.fmt[1])
      nx.value = tod_step(st.value, st.dir, hour_max(st.fmt));      // [RULE24]
    else if (cnt_tick)
      nx.value = st.dir ? st.value + 32'h00000001 : st.value - 32'h00000001; // [RULE4]
    // Postscaler counts timeouts up to the target
    ps_hit = timeout && st.ps_en && (st.ps_cnt == st.ps_target);    // [RULE16] [RULE17]
    if (timeout && st.ps_en)
      nx.ps_cnt = ps_hit ? 8'h01 : st.ps_cnt + 8'h01;               // [RULE16]
    // Capture on the first edge of the selected source
    nx.ev_prev = event_irq;
    capture = st.snap_en && event_valid(st.snap_sel) &&             // [RULE13] [RULE14]
              event_irq[st.snap_sel] && !st.ev_prev[st.snap_sel];   // [RULE11] [RULE12]
    if (capture)
      nx.snap = st.value;                                           // [RULE11]
    // AXI write channel capture
    if (s_axi_awvalid && st.awready)
    begin
      nx.aw_have = 1'b1;
      nx.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready)
    begin
      nx.w_have = 1'b1;
      nx.w_data = s_axi_wdata;
      nx.w_strb = s_axi_wstrb;
    end
    wr_fire = nx.aw_have && nx.w_have && !st.bvalid;
    cfg_new = merge(cfg_view, nx.w_data, nx.w_strb);
    // Interrupt clear first so a same-cycle event still sets it
    if (wr_fire && reg_hit(nx.aw_addr, OFF_IRQCLR))
    begin
      nx.irq = 1'b0;                                                // [RULE20]
      nx.match = 1'b0;
    end
    if (ps_hit)
      nx.match = 1'b1;                                              // [RULE18]
    if (st.origin ? ps_hit : timeout)                               // [RULE19] [RULE23]
      nx.irq = 1'b1;
    // Register writes
    if (wr_fire)
    begin
      nx.aw_have = 1'b0;
      nx.w_have = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = RESP_OKAY;
      if (reg_hit(nx.aw_addr, OFF_LOAD))
        nx.load = merge(st.load, nx.w_data, nx.w_strb);
      else if (reg_hit(nx.aw_addr, OFF_CONFIG))
      begin
        if (nx.w_strb[3])                                           // [RULE15]
          nx.ps_target = (cfg_new[CFG_PS_LSB +: 8] == 8'h00) ? 8'h01 : cfg_new[CFG_PS_LSB +: 8];
        nx.ps_en    = cfg_new[CFG_PS_EN];                           // [RULE17]
        nx.origin   = cfg_new[CFG_ORIGIN];                          // [RULE19]
        nx.snap_en  = cfg_new[CFG_SNAP_EN];                         // [RULE13]
        nx.snap_sel = cfg_new[CFG_SEL_LSB +: 5];
        nx.clk_sel  = gtp_clk_sel_t'(cfg_new[CFG_CLK_LSB +: 2]);    // [RULE10]
        nx.dir      = cfg_new[CFG_DIR];
        nx.run      = cfg_new[CFG_RUN];
        nx.mode     = cfg_new[CFG_MODE];
        nx.fmt      = gtp_fmt_t'(cfg_new[CFG_FMT_LSB +: 2]);        // [RULE3]
        nx.pre      = cfg_new[CFG_PRE_LSB +: 4];
      end
      else if (!reg_hit(nx.aw_addr, OFF_VALUE) && !reg_hit(nx.aw_addr, OFF_SNAP) &&
               !reg_hit(nx.aw_addr, OFF_IRQCLR))
        nx.bresp = RESP_SLVERR;
    end
    if (st.bvalid && s_axi_bready)
      nx.bvalid = 1'b0;
    nx.awready = !nx.aw_have && !nx.bvalid;
    nx.wready = !nx.w_have && !nx.bvalid;
    // AXI read channel
    rd_fire = s_axi_arvalid && st.arready;
    if (rd_fire)
    begin
      nx.rvalid = 1'b1;
      nx.rresp = RESP_OKAY;
      if (reg_hit(s_axi_araddr, OFF_LOAD))
        nx.rdata = st.load & fmt_mask;                              // [RULE1]
      else if (reg_hit(s_axi_araddr, OFF_VALUE))
        nx.rdata = st.value & fmt_mask;                             // [RULE1]
      else if (reg_hit(s_axi_araddr, OFF_CONFIG))
        nx.rdata = cfg_view;                                        // [RULE15] [RULE18]
      else if (reg_hit(s_axi_araddr, OFF_SNAP))
        nx.rdata = st.snap;
      else if (reg_hit(s_axi_araddr, OFF_IRQCLR))
        nx.rdata = 32'h00000000;
      else
      begin
        nx.rdata = 32'h00000000;
        nx.rresp = RESP_SLVERR;
      end
    end
    else if (st.rvalid && s_axi_rready)
      nx.rvalid = 1'b0;
    nx.arready = !nx.rvalid;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= RST_STATE;
    else
      st <= nx;
  end

  // Outputs straight from the state register
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rresp   = st.rresp;
  assign s_axi_rdata   = st.rdata;
  assign timer_irq     = st.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_clear_drops_irq: assert property (                            // [RULE20]
    wr_fire && reg_hit(nx.aw_addr, OFF_IRQCLR) && !timeout && !ps_hit |=> !timer_irq)
    else $error("interrupt not cleared by clear write");
  chk_timeout_raises: assert property (                             // [RULE23]
    timeout && !st.origin |=> timer_irq)
    else $error("timeout did not raise interrupt");
  chk_period_reload: assert property (                              // [RULE8]
    timeout && st.mode |=> st.value == ($past(st.load) & $past(fmt_mask)))
    else $error("periodic reload value wrong");
  chk_free_restart: assert property (                               // [RULE7]
    timeout && !st.mode && st.fmt == FMT_BIN |=> st.value == {32{!$past(st.dir)}})
    else $error("free-running restart value wrong");
  chk_up_step: assert property (                                    // [RULE4]
    cnt_tick && !timeout && st.fmt == FMT_BIN && st.dir |=> st.value == $past(st.value) + 1)
    else $error("up count step wrong");
  chk_stop_holds: assert property (                                 // [RULE5]
    !st.run ##1 !st.run |-> $stable(st.value))
    else $error("count moved while stopped");
  chk_capture_copy: assert property (                               // [RULE11]
    capture |=> st.snap == $past(st.value))
    else $error("capture did not copy count");
  chk_tod_gaps: assert property (                                   // [RULE1]
    rd_fire && st.fmt[1] && (reg_hit(s_axi_araddr, OFF_LOAD) || reg_hit(s_axi_araddr, OFF_VALUE))
    |=> (s_axi_rdata & ~TOD_MASK) == 32'h00000000)
    else $error("time-of-day reserved bits not zero");
  chk_div16_tick: assert property (                                 // [RULE9]
    cnt_tick && st.pre == 4'h4 |-> st.pre_cnt[3:0] == 4'hf)
    else $error("divide by 16 tick misplaced");
  chk_match_flag: assert property (                                 // [RULE18]
    ps_hit |=> st.match && st.ps_cnt == 8'h01)
    else $error("postscale match not flagged");
  chk_zero_target: assert property (                                // [RULE15]
    wr_fire && reg_hit(nx.aw_addr, OFF_CONFIG) && nx.w_strb[3] &&
    nx.w_data[31:24] == 8'h00 |=> st.ps_target == 8'h01)
    else $error("zero postscale target not one");
  chk_bvalid_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  cov_timeout: cover property (timeout ##1 timer_irq);
  cov_capture: cover property (capture);
  cov_match: cover property (ps_hit);
  cov_tod_wrap: cover property (timeout && st.fmt == FMT_TOD24);

endmodule : gtp_timer

// File: src/gtp_pkg.sv
// Constants, enumerations and the state carrier of the capture timer
package gtp_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] OFF_LOAD   = 32'hffff0320;
  localparam logic [31:0] OFF_VALUE  = 32'hffff0324;
  localparam logic [31:0] OFF_CONFIG = 32'hffff0328;
  localparam logic [31:0] OFF_IRQCLR = 32'hffff032c;
  localparam logic [31:0] OFF_SNAP   = 32'hffff0330;

  // ----------------------------------------------------------------
  // Configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_PS_LSB  = 24;
  localparam int CFG_PS_EN   = 23;
  localparam int CFG_MATCH   = 19;
  localparam int CFG_ORIGIN  = 18;
  localparam int CFG_SNAP_EN = 17;
  localparam int CFG_SEL_LSB = 12;
  localparam int CFG_CLK_LSB = 9;
  localparam int CFG_DIR     = 8;
  localparam int CFG_RUN     = 7;
  localparam int CFG_MODE    = 6;
  localparam int CFG_FMT_LSB = 4;
  localparam int CFG_PRE_LSB = 0;

  // ----------------------------------------------------------------
  // Reset values and count limits
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_LOAD     = 32'h00000000;
  localparam logic [31:0] RST_VALUE    = 32'hffffffff;
  localparam logic [31:0] RST_CONFIG   = 32'h01000000;
  localparam logic [31:0] RST_SNAP     = 32'h00000000;
  localparam logic [31:0] TOD_MASK     = 32'hff3f3f7f;
  localparam logic [6:0]  TOD_TICK_MAX = 7'h7f;
  localparam logic [5:0]  TOD_MS_MAX   = 6'h3b;
  localparam logic [7:0]  TOD_H24_MAX  = 8'h17;
  localparam logic [7:0]  TOD_H255_MAX = 8'hff;
  localparam int          NUM_EVENTS   = 18;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_OSC = 2'b00, CLK_CORE_DIV = 2'b01, CLK_CORE = 2'b10, CLK_PIN = 2'b11
  } gtp_clk_sel_t;

  typedef enum logic [1:0] {
    FMT_BIN = 2'b00, FMT_RSVD = 2'b01, FMT_TOD24 = 2'b10, FMT_TOD255 = 2'b11
  } gtp_fmt_t;

  // ----------------------------------------------------------------
  // Whole state of the timer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]           load;
    logic [31:0]           value;
    logic [31:0]           snap;
    logic [7:0]            ps_target;
    logic [7:0]            ps_cnt;
    logic                  ps_en;
    logic                  match;
    logic                  origin;
    logic                  snap_en;
    logic [4:0]            snap_sel;
    gtp_clk_sel_t          clk_sel;
    logic                  dir;
    logic                  run;
    logic                  mode;
    gtp_fmt_t              fmt;
    logic [3:0]            pre;
    logic [14:0]           pre_cnt;
    logic                  pin_prev;
    logic [NUM_EVENTS-1:0] ev_prev;
    logic                  irq;
    logic                  aw_have;
    logic                  w_have;
    logic [31:0]           aw_addr;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } gtp_state_t;

endpackage : gtp_pkg

// File: dv/gtp_timer_tb.sv
// Register-level testbench of the capture timer
`timescale 1ns/1ps
module general_timer_capture_postscale_tb
  import gtp_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        aclk    = 1'h0;
  logic        aresetn = 1'h0;
  logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0, r_d, rv;
  logic        aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic        aw_r, w_r, b_v, ar_r, r_v, irq;
  logic [1:0]  b_s, r_s, rs;
  logic [3:0]  src = 4'h0;
  logic        lp  = 1'h0;
  logic [17:0] ev  = 18'h0;
  logic [31:0] cyc = 32'h0;
  int          mismatches = 0;
  int          checked    = 0;

  // Free-running bench clock
  always #20 aclk = ~aclk;

  gtp_timer i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .osc_tick(src[0]), .core_div_tick(src[1]), .core_tick(src[2]),
    .external_count_pin(src[3]), .low_power_mode(lp), .event_irq(ev), .timer_irq(irq)
  );

  // ----------------------------------------------------------------
  // Bus, source and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    aw_a <= a;
    w_d  <= d;
    aw_v <= 1'h1;
    w_v  <= 1'h1;
    b_r  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (aw_v && aw_r) aw_v <= 1'h0;
      if (w_v && w_r) w_v <= 1'h0;
    end
    while (b_v !== 1'h1);
    rs = b_s;
    b_r <= 1'h0;
  endtask : wr

  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'h1;
    r_r  <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (ar_v && ar_r) ar_v <= 1'h0;
    end
    while (r_v !== 1'h1);
    rv = r_d;
    rs = r_s;
    r_r <= 1'h0;
  endtask : rd

  // Read a register and compare it
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask : rc

  // Pulse one count source n times, one idle cycle between pulses
  task automatic tick(input int i, input int n);
    repeat (n)
    begin
      @(posedge aclk);
      src[i] <= 1'h1;
      @(posedge aclk);
      src[i] <= 1'h0;
    end
    @(negedge aclk);
  endtask : tick

  task automatic ci(input logic e);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : ci

  task automatic wrap_up();
    $display("counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // Cut a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h4e20)
    begin
      mismatches++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rc(OFF_LOAD, RST_LOAD);
    rc(OFF_VALUE, RST_VALUE);
    rc(OFF_CONFIG, RST_CONFIG);
    rc(OFF_SNAP, RST_SNAP);
    rd(32'hffff0334);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    tick(0, 1);
    rc(OFF_VALUE, RST_VALUE);
    $display("test reset done");
    // Every format code, load read back in each
    wr(OFF_LOAD, 32'hffffffff);
    for (int f = 0; f < 4; f++)
    begin
      wr(OFF_CONFIG, 32'(f) << 4);
      rc(OFF_LOAD, (f > 1) ? TOD_MASK : 32'hffffffff);
      rc(OFF_CONFIG, RST_CONFIG | (32'(f) << 4));
    end
    $display("test format done");
    // Timeouts, free-running restarts and both directions
    wr(OFF_CONFIG, 32'h1c0);
    tick(0, 1);
    ci(1'h1);
    wr(OFF_IRQCLR, 32'h5a);
    ci(1'h0);
    wr(OFF_CONFIG, 32'h180);
    tick(0, 1);
    rc(OFF_VALUE, 32'h0);
    wr(OFF_CONFIG, 32'h80);
    tick(0, 1);
    rc(OFF_VALUE, 32'hffffffff);
    tick(0, 1);
    rc(OFF_VALUE, 32'hfffffffe);
    $display("test counting done");
    // Prescaler and clock sources
    wr(OFF_CONFIG, 32'h4);
    wr(OFF_CONFIG, 32'h84);
    tick(0, 15);
    rc(OFF_VALUE, 32'hfffffffe);
    tick(0, 1);
    rc(OFF_VALUE, 32'hfffffffd);
    wr(OFF_CONFIG, 32'h480);
    @(posedge aclk) lp <= 1'h1;
    tick(2, 1);
    tick(0, 1);
    rc(OFF_VALUE, 32'hfffffffd);
    @(posedge aclk) lp <= 1'h0;
    tick(2, 1);
    rc(OFF_VALUE, 32'hfffffffc);
    wr(OFF_CONFIG, 32'h280);
    tick(1, 1);
    rc(OFF_VALUE, 32'hfffffffb);
    wr(OFF_CONFIG, 32'h680);
    @(posedge aclk) lp <= 1'h1;
    tick(3, 1);
    rc(OFF_VALUE, 32'hfffffffa);
    @(posedge aclk) lp <= 1'h0;
    $display("test clocks done");
    // Capture on first assertion of the selected event only
    wr(OFF_CONFIG, 32'h29080);
    @(posedge aclk) ev[9] <= 1'h1;
    repeat (3) @(posedge aclk);
    rc(OFF_SNAP, 32'hfffffffa);
    tick(0, 1);
    rc(OFF_SNAP, 32'hfffffffa);
    rc(OFF_VALUE, 32'hfffffff9);
    wr(OFF_CONFIG, 32'h25080);
    @(posedge aclk) ev[5] <= 1'h1;
    repeat (3) @(posedge aclk);
    rc(OFF_SNAP, 32'hfffffffa);
    wr(OFF_CONFIG, 32'h09080);
    @(posedge aclk) ev[9] <= 1'h0;
    @(posedge aclk) ev[9] <= 1'h1;
    repeat (3) @(posedge aclk);
    rc(OFF_SNAP, 32'hfffffffa);
    $display("test capture done");
    // Postscaler: after seven ticks bring the count to full scale, every tick is a timeout with load at full scale
    wr(OFF_LOAD, 32'hffffffff);
    wr(OFF_CONFIG, 32'h1c0);
    tick(0, 7);
    wr(OFF_IRQCLR, 32'h0);
    wr(OFF_CONFIG, 32'h038401c0);
    tick(0, 2);
    ci(1'h0);
    rc(OFF_CONFIG, 32'h038401c0);
    tick(0, 1);
    ci(1'h1);
    rd(OFF_CONFIG);
    chk({31'h0, rv[CFG_MATCH]}, 32'h1);
    chk({24'h0, rv[31:24]}, 32'h1);
    wr(OFF_IRQCLR, 32'h1);
    wr(OFF_CONFIG, 32'h008401c0);
    tick(0, 1);
    ci(1'h1);
    $display("test postscale done");
    // Time-of-day carry from a periodic reload, 1/128 s ticks
    wr(OFF_LOAD, 32'h0a3b3b7f);
    wr(OFF_CONFIG, 32'h1c0);
    tick(0, 1);
    rc(OFF_VALUE, 32'h0a3b3b7f);
    wr(OFF_CONFIG, 32'h0);
    wr(OFF_CONFIG, 32'h1e8);
    tick(0, 256);
    rc(OFF_VALUE, 32'h0b000000);
    $display("test time-of-day done");
    wrap_up();
  end
endmodule : general_timer_capture_postscale_tb
